/* File: hdl/cell_expander.sv */
// cell expander: turns received bytes into nibble writes to config cells
// assumes bytes arrive as one-cycle strobes on the system clock
`timescale 1ns/1ps
module cell_expander (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_start,
	input wire logic i_valid,
	input wire logic i_compress,
	input wire logic [7:0] i_byte,
	output logic o_we,
	output logic [15:0] o_addr,
	output logic [3:0] o_data,
	output logic o_busy
);
	logic [4:0] left_reg, left_next;
	logic [7:0] pend_reg, pend_next;
	logic mode_reg, mode_next;
	logic [15:0] cnt_reg, cnt_next;
	logic we_reg, we_next;
	logic [15:0] addr_reg, addr_next;
	logic [3:0] data_reg, data_next;

	// next write: one nibble per cycle while a byte is pending
	always_comb begin
		left_next = left_reg;
		pend_next = pend_reg;
		mode_next = mode_reg;
		cnt_next = cnt_reg;
		we_next = 1'b0;
		addr_next = addr_reg;
		data_next = data_reg;
		if (i_start) begin
			cnt_next = cfg_loader_pkg::ADDR_RESET;
			left_next = '0;
		end else if (left_reg != '0) begin
			we_next = 1'b1;
			addr_next = cnt_reg;
			data_next = pend_reg[3:0];
			cnt_next = cnt_reg + 16'h0001;
			left_next = left_reg - 5'h01;
			if (!mode_reg)
				pend_next = {4'h0, pend_reg[7:4]}; // second nibble next
		end
		if (!i_start && i_valid && left_reg == '0) begin
			mode_next = i_compress;
			pend_next = i_byte;
			if (i_compress) begin
				// run of count plus one copies of the low nibble
				left_next = {1'b0, i_byte[cfg_loader_pkg::RUN_HI:
					cfg_loader_pkg::RUN_LO]} + 5'h01;
			end else begin
				left_next = cfg_loader_pkg::PLAIN_WRITES;
			end
		end
	end

	// register expander state
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			left_reg <= '0;
			pend_reg <= '0;
			mode_reg <= 1'b0;
			cnt_reg <= cfg_loader_pkg::ADDR_RESET;
			we_reg <= 1'b0;
			addr_reg <= cfg_loader_pkg::ADDR_RESET;
			data_reg <= '0;
		end else begin
			left_reg <= left_next;
			pend_reg <= pend_next;
			mode_reg <= mode_next;
			cnt_reg <= cnt_next;
			we_reg <= we_next;
			addr_reg <= addr_next;
			data_reg <= data_next;
		end
	end

	assign o_we = we_reg;
	assign o_addr = addr_reg;
	assign o_data = data_reg;
	assign o_busy = (left_reg != '0);

	// accepted byte reaches the cells two cycles later
	property p_first_write;
		@(posedge i_clock) disable iff (!i_nrst)
		i_valid && !o_busy && !i_start |-> ##2 (o_we &&
			o_data == $past(i_byte[3:0], 2));
	endproperty
	a_first_write: assert property (p_first_write)
		else $error("accepted byte not written to cells");

	// a zero-count run gives exactly one write
	property p_single_run;
		@(posedge i_clock) disable iff (!i_nrst)
		i_valid && !o_busy && !i_start && i_compress &&
			i_byte[7:4] == 4'h0 |-> ##2 o_we ##1 !o_we;
	endproperty
	a_single_run: assert property (p_single_run)
		else $error("zero-count run wrote wrong number of nibbles");

	// plain byte gives low then high nibble at consecutive addresses
	property p_plain_pair;
		@(posedge i_clock) disable iff (!i_nrst)
		i_valid && !o_busy && !i_start && !i_compress |-> ##3
			(o_we && o_data == $past(i_byte[7:4], 3) &&
			o_addr == $past(o_addr) + 16'h0001);
	endproperty
	a_plain_pair: assert property (p_plain_pair)
		else $error("plain byte nibbles out of order");

	c_long_run: cover property (@(posedge i_clock) disable iff (!i_nrst)
		i_valid && i_compress && i_byte[7:4] == 4'hf);
endmodule // cell_expander

/* File: hdl/cfg_loader_pkg.sv */
// constants shared by the configuration loader and its cell expander
// assumes one 100 MHz system clock; the load clock pin is sampled by it
package cfg_loader_pkg;
	// load schemes, chosen by strap-like logic before a load starts
	localparam logic [1:0] SCHEME_PARALLEL = 2'h0;
	localparam logic [1:0] SCHEME_ACTIVE_SERIAL = 2'h1;
	localparam logic [1:0] SCHEME_PASSIVE_SERIAL = 2'h2;
	localparam logic [1:0] SCHEME_BOUNDARY_SCAN = 2'h3;
	// widths
	localparam int DATA_W = 8;
	localparam int NIB_W = 4;
	localparam int ADDR_W = 16;
	localparam int LEFT_W = 5;
	localparam int SYNC_DEPTH = 3;
	// header byte field: image carries compressed data
	localparam int HDR_COMPRESS_BIT = 0;
	// compressed byte layout: repeat count high, nibble value low
	localparam int RUN_HI = 7;
	localparam int RUN_LO = 4;
	// parallel compressed: one word per four load clock edges
	localparam logic [1:0] BEAT_TAKE = 2'h0;
	// uncompressed byte gives two nibble writes
	localparam logic [4:0] PLAIN_WRITES = 5'h02;
	// serial byte assembly: last bit index
	localparam logic [2:0] SER_LAST_BIT = 3'h7;
	// reset values
	localparam logic [15:0] ADDR_RESET = 16'h0000;
endpackage

/* File: hdl/compressed_config_loader.sv */
// configuration loader: receives a bitstream over the load pins,
// expands it when the image says it is compressed and the scheme is not boundary scan, writes the cells
// assumes the load clock pin is far slower than i_clock and that
// i_load_enable and i_scheme come from logic on i_clock
`timescale 1ns/1ps
module compressed_config_loader (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_load_enable,
	input wire logic [1:0] i_scheme,
	input wire logic i_config_load_clock,
	input wire logic [7:0] i_config_data,
	output logic o_cell_we,
	output logic [15:0] o_cell_addr,
	output logic [3:0] o_cell_data,
	output logic o_compressed,
	output logic o_loading,
	output logic o_overrun
);
	typedef enum logic [1:0] {ST_IDLE, ST_HEADER, ST_LOAD} load_state_t;

	logic [8:0] sync_reg [cfg_loader_pkg::SYNC_DEPTH];
	logic clk_stable_reg, clk_stable_next;
	logic rise_reg, rise_next;
	logic [7:0] word_reg, word_next;
	load_state_t state_reg, state_next;
	logic [1:0] scheme_reg, scheme_next;
	logic compressed_reg, compressed_next;
	logic [1:0] beat_reg, beat_next;
	logic [2:0] bit_reg, bit_next;
	logic [7:0] shift_reg, shift_next;
	logic overrun_reg, overrun_next;
	logic loading_reg, loading_next;
	logic byte_valid;
	logic [7:0] byte_data;
	logic start;
	logic exp_busy;

	// pin synchroniser, three stages for clock and data
	genvar g;
	generate
		for (g = 0; g < cfg_loader_pkg::SYNC_DEPTH; g++) begin : g_sync
			if (g == 0) begin : g_first
				// first stage takes the raw pins
				always_ff @(posedge i_clock or negedge i_nrst) begin
					if (!i_nrst)
						sync_reg[g] <= '0;
					else
						sync_reg[g] <= {i_config_load_clock, i_config_data};
				end
			end else begin : g_next
				// later stages only follow the stage before
				always_ff @(posedge i_clock or negedge i_nrst) begin
					if (!i_nrst)
						sync_reg[g] <= '0;
					else
						sync_reg[g] <= sync_reg[g - 1];
				end
			end
		end
	endgenerate

	// load clock level counts once stages two and three agree
	always_comb begin
		clk_stable_next = clk_stable_reg;
		if (sync_reg[1][8] == sync_reg[2][8])
			clk_stable_next = sync_reg[2][8];
		rise_next = clk_stable_next && !clk_stable_reg;
		word_next = rise_next ? sync_reg[2][7:0] : word_reg;
	end

	// register edge finder
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			clk_stable_reg <= 1'b0;
			rise_reg <= 1'b0;
			word_reg <= '0;
		end else begin
			clk_stable_reg <= clk_stable_next;
			rise_reg <= rise_next;
			word_reg <= word_next;
		end
	end

	// byte assembly per scheme and load sequencing
	always_comb begin
		state_next = state_reg;
		scheme_next = scheme_reg;
		compressed_next = compressed_reg;
		beat_next = beat_reg;
		bit_next = bit_reg;
		shift_next = shift_reg;
		overrun_next = overrun_reg;
		byte_valid = 1'b0;
		byte_data = word_reg;
		start = 1'b0;
		// serial schemes: lsb first on data bit zero
		if (rise_reg && scheme_reg != cfg_loader_pkg::SCHEME_PARALLEL &&
				state_reg != ST_IDLE) begin
			shift_next = {word_reg[0], shift_reg[7:1]};
			bit_next = bit_reg + 3'h1;
			if (bit_reg == cfg_loader_pkg::SER_LAST_BIT) begin
				byte_valid = 1'b1;
				byte_data = {word_reg[0], shift_reg[7:1]};
			end
		end
		// parallel: one word per edge, or per four when compressed
		if (rise_reg && scheme_reg == cfg_loader_pkg::SCHEME_PARALLEL &&
				state_reg != ST_IDLE) begin
			if (state_reg == ST_LOAD && compressed_reg) begin
				beat_next = beat_reg + 2'h1;
				byte_valid = (beat_reg == cfg_loader_pkg::BEAT_TAKE);
			end else begin
				byte_valid = 1'b1;
			end
		end
		case (state_reg)
			ST_IDLE: begin
				if (i_load_enable) begin
					state_next = ST_HEADER;
					scheme_next = i_scheme;
					compressed_next = 1'b0;
					overrun_next = 1'b0;
					beat_next = '0;
					bit_next = '0;
					start = 1'b1;
				end
			end
			ST_HEADER: begin
				if (byte_valid) begin
					state_next = ST_LOAD;
					beat_next = '0;
					// own header decides; boundary scan never expands
					compressed_next =
						byte_data[cfg_loader_pkg::HDR_COMPRESS_BIT] &&
						scheme_reg != cfg_loader_pkg::SCHEME_BOUNDARY_SCAN;
				end
			end
			ST_LOAD: begin
				if (byte_valid && exp_busy)
					overrun_next = 1'b1;
			end
			default: state_next = ST_IDLE;
		endcase
		if (!i_load_enable)
			state_next = ST_IDLE;
		loading_next = (state_next != ST_IDLE); // registered status
	end

	// register load state
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg <= ST_IDLE;
			scheme_reg <= cfg_loader_pkg::SCHEME_PARALLEL;
			compressed_reg <= 1'b0;
			beat_reg <= '0;
			bit_reg <= '0;
			shift_reg <= '0;
			overrun_reg <= 1'b0;
			loading_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			scheme_reg <= scheme_next;
			compressed_reg <= compressed_next;
			beat_reg <= beat_next;
			bit_reg <= bit_next;
			shift_reg <= shift_next;
			overrun_reg <= overrun_next;
			loading_reg <= loading_next;
		end
	end

	// expander writes cells as bytes arrive, no image buffer
	cell_expander u_expander (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_start(start),
		.i_valid(byte_valid && state_reg == ST_LOAD),
		.i_compress(compressed_reg),
		.i_byte(byte_data),
		.o_we(o_cell_we),
		.o_addr(o_cell_addr),
		.o_data(o_cell_data),
		.o_busy(exp_busy)
	);

	assign o_compressed = compressed_reg;
	assign o_loading = loading_reg;
	assign o_overrun = overrun_reg;

	// header byte sets the mode for the rest of the image
	property p_header_mode;
		@(posedge i_clock) disable iff (!i_nrst)
		state_reg == ST_HEADER && byte_valid && i_load_enable |=>
			compressed_reg == ($past(byte_data[0]) &&
			scheme_reg != cfg_loader_pkg::SCHEME_BOUNDARY_SCAN);
	endproperty
	a_header_mode: assert property (p_header_mode)
		else $error("header byte did not set compression mode");

	// boundary-scan loads never expand
	property p_bscan_plain;
		@(posedge i_clock) disable iff (!i_nrst)
		scheme_reg == cfg_loader_pkg::SCHEME_BOUNDARY_SCAN |->
			!compressed_reg;
	endproperty
	a_bscan_plain: assert property (p_bscan_plain)
		else $error("compression active on boundary-scan load");

	// mode fixed for the whole image once loading
	property p_mode_hold;
		@(posedge i_clock) disable iff (!i_nrst)
		state_reg == ST_LOAD && $past(state_reg) == ST_LOAD |->
			$stable(compressed_reg);
	endproperty
	a_mode_hold: assert property (p_mode_hold)
		else $error("compression mode changed mid image");

	// parallel compressed word taken, then no word taken for the next six cycles
	property p_four_beats;
		@(posedge i_clock) disable iff (!i_nrst)
		byte_valid && state_reg == ST_LOAD && compressed_reg &&
			scheme_reg == cfg_loader_pkg::SCHEME_PARALLEL |=>
			!byte_valid [*6];
	endproperty
	a_four_beats: assert property (p_four_beats)
		else $error("parallel compressed word taken too early");

	// expander idle whenever a byte arrives
	property p_keep_up;
		@(posedge i_clock) disable iff (!i_nrst)
		byte_valid && state_reg == ST_LOAD |-> !exp_busy;
	endproperty
	a_keep_up: assert property (p_keep_up)
		else $error("expander still busy when next byte arrived");

	// accepted serial schemes all reach the cells
	property p_serial_write;
		@(posedge i_clock) disable iff (!i_nrst)
		byte_valid && state_reg == ST_LOAD && i_load_enable &&
			scheme_reg != cfg_loader_pkg::SCHEME_PARALLEL |->
			##[1:2] o_cell_we;
	endproperty
	a_serial_write: assert property (p_serial_write)
		else $error("serial byte produced no cell write");

	c_par_comp: cover property (@(posedge i_clock) disable iff (!i_nrst)
		byte_valid && state_reg == ST_LOAD && compressed_reg &&
		scheme_reg == cfg_loader_pkg::SCHEME_PARALLEL);
	c_ser_comp: cover property (@(posedge i_clock) disable iff (!i_nrst)
		o_cell_we && compressed_reg &&
		scheme_reg == cfg_loader_pkg::SCHEME_PASSIVE_SERIAL);
	c_bscan: cover property (@(posedge i_clock) disable iff (!i_nrst)
		o_cell_we && scheme_reg == cfg_loader_pkg::SCHEME_BOUNDARY_SCAN);
endmodule // compressed_config_loader

/* File: testbench/cfg_source_model.sv */
// configuration source model: drives the load clock and data pins
// assumes the caller starts each frame just after a system clock fall
`timescale 1ns/1ps
module cfg_source_model (
	output logic o_config_load_clock,
	output logic [7:0] o_config_data
);
	// idle: load clock stands still low between frames
	initial begin
		o_config_load_clock = 1'b0;
		o_config_data = 8'hff;
	end
	// one word held over a number of 160 ns load clock periods
	task automatic put_word(input logic [7:0] w, input int edges);
		#40 o_config_data = w;
		#40 o_config_load_clock = 1'b1;
		#80 o_config_load_clock = 1'b0;
		// word stays put across every edge of its beat
		for (int e = 1; e < edges; e++) begin
			#80 o_config_load_clock = 1'b1;
			#80 o_config_load_clock = 1'b0;
		end
		o_config_data = ~w; // released: inverse of last word
	endtask
	// serial sends bit 0 LSB first; parallel holds the word
	task automatic send_byte(input logic [7:0] b, input logic serial,
		input int edges);
		#3;
		if (serial) begin
			for (int i = 0; i < 8; i++) begin
				put_word({7'h00, b[i]}, 1);
			end
		end else begin
			put_word(b, edges);
		end
	endtask
endmodule // cfg_source_model

/* File: testbench/tb_compressed_config_loader.sv */
// testbench for the configuration loader: loads every scheme in turn
// assumes the source model and the loader files are compiled first
`timescale 1ns/1ps
module tb_compressed_config_loader;
	logic i_clock;
	logic i_nrst;
	logic i_load_enable;
	logic [1:0] i_scheme;
	logic i_config_load_clock;
	logic [7:0] i_config_data;
	logic o_cell_we;
	logic [15:0] o_cell_addr;
	logic [3:0] o_cell_data;
	logic o_compressed;
	logic o_loading;
	logic o_overrun;
	int bad_count;
	int check_count;
	logic [19:0] exp_q[$];
	logic [15:0] next_addr;
	logic [31:0] rng;

	compressed_config_loader u_dut (
		.i_clock(i_clock), .i_nrst(i_nrst), .i_load_enable(i_load_enable),
		.i_scheme(i_scheme), .i_config_load_clock(i_config_load_clock),
		.i_config_data(i_config_data), .o_cell_we(o_cell_we),
		.o_cell_addr(o_cell_addr), .o_cell_data(o_cell_data),
		.o_compressed(o_compressed), .o_loading(o_loading),
		.o_overrun(o_overrun)
	);
	cfg_source_model u_src (
		.o_config_load_clock(i_config_load_clock),
		.o_config_data(i_config_data)
	);

	// 100 MHz system clock
	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end

	// xorshift step
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		xs = y ^ (y << 5);
	endfunction

	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// note the cell writes that one byte must produce
	task automatic expect_byte(input logic [7:0] b, input logic comp);
		if (comp) begin
			for (int i = 0; i <= int'(b[7:4]); i++) begin
				exp_q.push_back({next_addr, b[3:0]});
				next_addr = next_addr + 16'h0001;
			end
		end else begin
			exp_q.push_back({next_addr, b[3:0]});
			exp_q.push_back({next_addr + 16'h0001, b[7:4]});
			next_addr = next_addr + 16'h0002;
		end
	endtask

	// one whole load: header then n random image bytes
	task automatic run_load(input logic [1:0] scheme, input logic c,
		input int n);
		logic comp;
		logic ser;
		logic [7:0] b;
		int k;
		comp = c && (scheme != cfg_loader_pkg::SCHEME_BOUNDARY_SCAN);
		// every scheme but the parallel one shifts bit 0 in
		ser = (scheme != cfg_loader_pkg::SCHEME_PARALLEL);
		next_addr = cfg_loader_pkg::ADDR_RESET;
		@(negedge i_clock);
		i_scheme = scheme;
		i_load_enable = 1'b1;
		repeat (4) @(negedge i_clock);
		check(20'(o_loading), 20'h00001);
		rng = xs(rng);
		u_src.send_byte({rng[7:1], c}, ser, 1);
		for (k = 0; k < n; k++) begin
			rng = xs(rng);
			b = rng[7:0];
			expect_byte(b, comp);
			u_src.send_byte(b, ser, (comp && !ser) ? 4 : 1);
		end
		for (k = 0; k < 200 && exp_q.size() != 0; k++) begin
			@(negedge i_clock);
		end
		check(20'(exp_q.size()), 20'h00000);
		if (exp_q.size() != 0) begin
			end_of_test();
		end
		check(20'(o_compressed), 20'(comp));
		check(20'(o_overrun), 20'h00000);
		i_load_enable = 1'b0;
		repeat (3) @(negedge i_clock);
		check(20'(o_loading), 20'h00000);
		$display("load done scheme %0d header bit %0d", scheme, c);
	endtask

	// watcher: every cell write takes the oldest note
	always @(negedge i_clock) begin
		if (o_cell_we === 1'b1) begin
			if (exp_q.size() == 0) begin
				check({o_cell_addr, o_cell_data}, 20'hfffff);
			end else begin
				check({o_cell_addr, o_cell_data}, exp_q.pop_front());
			end
		end
	end

	// main sequence
	initial begin
		bad_count = 0;
		check_count = 0;
		rng = 32'h00000048;
		i_nrst = 1'b0;
		i_load_enable = 1'b0;
		i_scheme = cfg_loader_pkg::SCHEME_PARALLEL;
		repeat (8) @(negedge i_clock);
		check(20'({o_cell_we, o_compressed, o_loading, o_overrun}), 20'h0);
		i_nrst = 1'b1;
		// edges with no load enabled must write nothing
		u_src.send_byte(8'ha5, 1'b0, 1);
		repeat (20) @(negedge i_clock);
		check(20'(o_loading), 20'h00000);
		$display("idle edges done");
		// every scheme with header bit clear and set; compressed image for all but boundary scan
		for (int s = 0; s < 4; s++) begin
			run_load(2'(s), 1'b0, 4);
			run_load(2'(s), 1'b1, 4);
		end
		end_of_test();
	end
endmodule // tb_compressed_config_loader
